//--- logic/frsc_cfg.svh
// Purpose: Constants for the frequency register select block
// Assumes: 40 MHz core clock, serial link sampled on that clock
// Notes: Register addresses are 4-bit serial addresses
`ifndef FRSC_CFG_SVH
`define FRSC_CFG_SVH

`define FRSC_ADDR_W 4
`define FRSC_DATA_W 32
`define FRSC_HDR_BITS 6'h05
`define FRSC_FRAME_BITS 6'h25

`define FRSC_ADDR_RATE_LOCK 4'h0
`define FRSC_ADDR_FREQ0 4'h1
`define FRSC_ADDR_FREQ1 4'h2
`define FRSC_ADDR_FREQ2 4'h3
`define FRSC_ADDR_FREQ3 4'h4
`define FRSC_ADDR_STATUS 4'h5

`define FRSC_RATE_LOCK_RESET 32'h00000057
`define FRSC_FREQ_RESET 32'h00000000

`define FRSC_RATE_MSB 31
`define FRSC_RATE_LSB 18
`define FRSC_STEP_MSB 17
`define FRSC_STEP_LSB 10
`define FRSC_LOCK_DETECT_CLOCK_DOUBLE_BIT 9
`define FRSC_UNLOCK_MSB 8
`define FRSC_UNLOCK_LSB 5
`define FRSC_LOCK_MSB 4
`define FRSC_LOCK_LSB 0

`endif

//--- logic/frsc_pkg.sv
// Purpose: Types for the frequency register select block
// Assumes: Constants live in frsc_cfg.svh
// Notes: Serial states are one-hot
package frsc_pkg;
   typedef enum logic [3:0] {
      FRSC_IDLE = 4'h1,
      FRSC_HDR = 4'h2,
      FRSC_LOAD = 4'h4,
      FRSC_DATA = 4'h8
   } frsc_ser_state_type;
endpackage

//--- logic/frsc_serial.sv
// Purpose: Three-wire serial slave framing for register access
// Assumes: Serial pins synchronous to clock_in, serial clock much slower
// Notes: Frame = R/W bit, 4 address bits, 32 data bits, MSB first
`include "frsc_cfg.svh"
module frsc_serial (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ser_clk_in,
   input wire logic ser_load_n_in,
   input wire logic ser_data_in,
   output logic ser_data_out,
   output logic ser_data_oe_out,
   output logic [`FRSC_ADDR_W-1:0] addr_out,
   output logic [`FRSC_DATA_W-1:0] wdata_out,
   output logic wr_pulse_out,
   input wire logic [`FRSC_DATA_W-1:0] rd_data_in
);
   frsc_pkg::frsc_ser_state_type state_ff, nxt_state;
   logic sclk_ff, nxt_sclk;
   logic rd_ff, nxt_rd;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [`FRSC_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [`FRSC_DATA_W-1:0] sh_ff, nxt_sh;
   logic wr_ff, nxt_wr;
   logic rise;

   assign rise = ser_clk_in & ~sclk_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_sclk = ser_clk_in;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      nxt_sh = sh_ff;
      nxt_wr = 1'b0;
      if (ser_load_n_in) begin
         // Frame end: a write commits only when every bit arrived
         if (state_ff == frsc_pkg::FRSC_DATA && !rd_ff && cnt_ff == `FRSC_FRAME_BITS) begin
            nxt_wr = 1'b1;
         end
         nxt_state = frsc_pkg::FRSC_IDLE;
         nxt_cnt = 6'h00;
      end else begin
         case (state_ff)
            frsc_pkg::FRSC_IDLE: begin
               nxt_state = frsc_pkg::FRSC_HDR;
               nxt_cnt = 6'h00;
            end
            frsc_pkg::FRSC_HDR: begin
               if (rise) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  if (cnt_ff == 6'h00) begin
                     nxt_rd = ser_data_in;
                  end else begin
                     nxt_addr = {addr_ff[`FRSC_ADDR_W-2:0], ser_data_in};
                  end
                  if (cnt_ff + 6'h01 == `FRSC_HDR_BITS) begin
                     nxt_state = frsc_pkg::FRSC_LOAD;
                  end
               end
            end
            frsc_pkg::FRSC_LOAD: begin
               nxt_sh = rd_data_in;
               nxt_state = frsc_pkg::FRSC_DATA;
            end
            frsc_pkg::FRSC_DATA: begin
               if (rise && cnt_ff != `FRSC_FRAME_BITS) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  nxt_sh = {sh_ff[`FRSC_DATA_W-2:0], ser_data_in};
               end
            end
            default: nxt_state = frsc_pkg::FRSC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_ff <= frsc_pkg::FRSC_IDLE;
         sclk_ff <= 1'b0;
         rd_ff <= 1'b0;
         cnt_ff <= 6'h00;
         addr_ff <= 4'h0;
         sh_ff <= 32'h00000000;
         wr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_ff <= nxt_sclk;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
         sh_ff <= nxt_sh;
         wr_ff <= nxt_wr;
      end
   end

   assign ser_data_out = sh_ff[`FRSC_DATA_W-1];
   assign ser_data_oe_out = rd_ff && state_ff == frsc_pkg::FRSC_DATA && !ser_load_n_in;
   assign addr_out = addr_ff;
   assign wdata_out = sh_ff;
   assign wr_pulse_out = wr_ff;
endmodule

//--- logic/frsc_top.sv
// Purpose: Rate/lock control word, four frequency codes and frequency selection
// Assumes: First control register fields and status word arrive as inputs
// Notes: Registers reached only over the three-wire serial link
//
// Contract
// [RULE1] 14-bit rate field; nonzero enables data clock
// [RULE2] Host programs rate within 1 to 100 kbps
// [RULE3] 8-bit sync step size, resets zero
// [RULE4] Double lock clock bit: 0 10 MHz
// [RULE5] 4-bit unlock trigger count resets to 0010
// [RULE6] 5-bit lock trigger count resets to 10111
// [RULE7] Four independent 32-bit frequency code registers
// [RULE8] Host writes all codes before RX or TX
// [RULE9] Receive: receive select field picks register
// [RULE10] Transmit: select bit picks pair, pin picks one
// [RULE11] After reset: TX uses 0/1, RX uses 2
// [RULE12] Control bit 5 inverts pin-to-symbol mapping
// [RULE13] Select bits alone switch between two channels
// [RULE14] Status register read-only, writes ignored
// [RULE15] Rate and lock control resets to 0000057 hex
// [RULE16] Selector combinational; registers change on writes
`include "frsc_cfg.svh"
module frsc_top (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ser_clk_in,
   input wire logic ser_load_n_in,
   input wire logic ser_data_in,
   output logic ser_data_out,
   output logic ser_data_oe_out,
   input wire logic direction_select_in,
   input wire logic [1:0] receive_select_field_in,
   input wire logic transmit_select_bit_in,
   input wire logic data_polarity_direct_in,
   input wire logic message_data_pin_in,
   input wire logic [`FRSC_DATA_W-1:0] status_word_in,
   output logic [13:0] received_message_rate_out,
   output logic recovered_data_clock_enable_out,
   output logic [7:0] sync_step_size_out,
   output logic lock_detect_clock_double_out,
   output logic [3:0] unlock_trigger_count_out,
   output logic [4:0] lock_trigger_count_out,
   output logic [1:0] freq_select_index_out,
   output logic [`FRSC_DATA_W-1:0] freq_code_out
);
   // Reset word of the rate and lock control register, split per field below
   localparam logic [`FRSC_DATA_W-1:0] CTRL_RESET_WORD = `FRSC_RATE_LOCK_RESET;
   logic [13:0] rate_ff, nxt_rate;
   logic [7:0] step_ff, nxt_step;
   logic lock_detect_clock_double_ff, nxt_lock_detect_clock_double;
   logic [3:0] unlock_ff, nxt_unlock;
   logic [4:0] lock_ff, nxt_lock;
   logic [`FRSC_DATA_W-1:0] ctrl_word;
   logic ctrl_wr;
   logic [3:0] freq_wr;
   logic [1:0] tx_index;
   logic [`FRSC_DATA_W-1:0] freq_ff [0:3];
   logic [`FRSC_DATA_W-1:0] nxt_freq [0:3];
   logic [`FRSC_ADDR_W-1:0] addr;
   logic [`FRSC_DATA_W-1:0] wdata;
   logic [`FRSC_DATA_W-1:0] rd_data;
   logic wr_pulse;
   logic symbol;

   frsc_serial u_serial (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ser_clk_in(ser_clk_in),
      .ser_load_n_in(ser_load_n_in),
      .ser_data_in(ser_data_in),
      .ser_data_out(ser_data_out),
      .ser_data_oe_out(ser_data_oe_out),
      .addr_out(addr),
      .wdata_out(wdata),
      .wr_pulse_out(wr_pulse),
      .rd_data_in(rd_data)
   );

   // Maps a frequency address to its code index
   function automatic logic [1:0] freq_index(input logic [`FRSC_ADDR_W-1:0] a);
      logic [`FRSC_ADDR_W-1:0] d;
      d = a - `FRSC_ADDR_FREQ0;
      return d[1:0];
   endfunction

   function automatic logic is_freq(input logic [`FRSC_ADDR_W-1:0] a);
      return a >= `FRSC_ADDR_FREQ0 && a <= `FRSC_ADDR_FREQ3;
   endfunction

   function automatic logic is_ctrl(input logic [`FRSC_ADDR_W-1:0] a);
      return a == `FRSC_ADDR_RATE_LOCK;
   endfunction

   function automatic logic is_status(input logic [`FRSC_ADDR_W-1:0] a);
      return a == `FRSC_ADDR_STATUS;
   endfunction

   // Field slices of a control word, shared by the write path and reset
   function automatic logic [13:0] rate_field(input logic [`FRSC_DATA_W-1:0] w);
      return w[`FRSC_RATE_MSB:`FRSC_RATE_LSB];
   endfunction

   function automatic logic [7:0] step_field(input logic [`FRSC_DATA_W-1:0] w);
      return w[`FRSC_STEP_MSB:`FRSC_STEP_LSB];
   endfunction

   function automatic logic [3:0] unlock_field(input logic [`FRSC_DATA_W-1:0] w);
      return w[`FRSC_UNLOCK_MSB:`FRSC_UNLOCK_LSB];
   endfunction

   function automatic logic [4:0] lock_field(input logic [`FRSC_DATA_W-1:0] w);
      return w[`FRSC_LOCK_MSB:`FRSC_LOCK_LSB];
   endfunction

   // Write strobes; status and unmapped addresses raise none
   always_comb begin
      ctrl_wr = 1'b0;
      freq_wr = 4'h0;
      if (wr_pulse) begin
         if (is_ctrl(addr)) begin
            ctrl_wr = 1'b1;
         end else if (is_freq(addr)) begin
            freq_wr[freq_index(addr)] = 1'b1; // RULE7
         end else if (is_status(addr)) begin
            // Status is read-only, so the word is dropped
            ctrl_wr = 1'b0; // RULE14
         end
      end
   end

   always_comb begin
      nxt_rate = rate_ff;
      nxt_step = step_ff;
      nxt_lock_detect_clock_double = lock_detect_clock_double_ff;
      nxt_unlock = unlock_ff;
      nxt_lock = lock_ff;
      if (ctrl_wr) begin
         nxt_rate = rate_field(wdata); // RULE1
         nxt_step = step_field(wdata); // RULE3
         nxt_lock_detect_clock_double = wdata[`FRSC_LOCK_DETECT_CLOCK_DOUBLE_BIT]; // RULE4
         nxt_unlock = unlock_field(wdata); // RULE5
         nxt_lock = lock_field(wdata); // RULE6
      end
   end

   // Codes move only on a completed write, never while the selector switches
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nxt_freq[i] = freq_wr[i] ? wdata : freq_ff[i]; // RULE7
      end
   end

   // Each field takes its slice of the one reset word
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rate_ff <= rate_field(CTRL_RESET_WORD); // RULE15
         step_ff <= step_field(CTRL_RESET_WORD); // RULE3
         lock_detect_clock_double_ff <= CTRL_RESET_WORD[`FRSC_LOCK_DETECT_CLOCK_DOUBLE_BIT]; // RULE4
         unlock_ff <= unlock_field(CTRL_RESET_WORD); // RULE5
         lock_ff <= lock_field(CTRL_RESET_WORD); // RULE6
      end else begin
         rate_ff <= nxt_rate; // RULE16
         step_ff <= nxt_step;
         lock_detect_clock_double_ff <= nxt_lock_detect_clock_double;
         unlock_ff <= nxt_unlock;
         lock_ff <= nxt_lock;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < 4; i++) begin
            freq_ff[i] <= `FRSC_FREQ_RESET;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            freq_ff[i] <= nxt_freq[i]; // RULE16
         end
      end
   end

   assign ctrl_word = {rate_ff, step_ff, lock_detect_clock_double_ff, unlock_ff, lock_ff};

   always_comb begin
      if (is_ctrl(addr)) begin
         rd_data = ctrl_word;
      end else if (is_freq(addr)) begin
         rd_data = freq_ff[freq_index(addr)];
      end else if (is_status(addr)) begin
         rd_data = status_word_in; // RULE14
      end else begin
         rd_data = 32'h00000000;
      end
   end

   assign received_message_rate_out = rate_ff; // RULE1
   // A zero rate leaves the recovered data clock stopped
   assign recovered_data_clock_enable_out = |rate_ff; // RULE1
   assign sync_step_size_out = step_ff; // RULE3
   assign lock_detect_clock_double_out = lock_detect_clock_double_ff; // RULE4
   assign unlock_trigger_count_out = unlock_ff; // RULE5
   assign lock_trigger_count_out = lock_ff; // RULE6

   // Direct polarity passes the pin, inverted polarity flips it
   assign symbol = message_data_pin_in ^ ~data_polarity_direct_in; // RULE12

   // Pin level picks within the pair named by the transmit select bit
   assign tx_index = {transmit_select_bit_in, symbol}; // RULE10

   always_comb begin
      if (direction_select_in) begin
         freq_select_index_out = tx_index; // RULE10 RULE11 RULE13
      end else begin
         freq_select_index_out = receive_select_field_in; // RULE9 RULE11 RULE13
      end
   end

   assign freq_code_out = freq_ff[freq_select_index_out]; // RULE16
endmodule

//--- testbench/frsc_monitor.sv
// Purpose: Port checks for frsc_top
// Assumes: One clock domain, synchronous reset
// Notes: Bound to every frsc_top below
module frsc_monitor (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ser_load_n_in,
   input wire logic ser_data_oe_out,
   input wire logic direction_select_in,
   input wire logic [1:0] receive_select_field_in,
   input wire logic transmit_select_bit_in,
   input wire logic data_polarity_direct_in,
   input wire logic message_data_pin_in,
   input wire logic [13:0] received_message_rate_out,
   input wire logic recovered_data_clock_enable_out,
   input wire logic [7:0] sync_step_size_out,
   input wire logic lock_detect_clock_double_out,
   input wire logic [3:0] unlock_trigger_count_out,
   input wire logic [4:0] lock_trigger_count_out,
   input wire logic [1:0] freq_select_index_out,
   input wire logic [31:0] freq_code_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ctl;
   assign ctl = {received_message_rate_out, sync_step_size_out, lock_detect_clock_double_out,
      unlock_trigger_count_out, lock_trigger_count_out};
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   a_clk_en_rate: assert property (
      recovered_data_clock_enable_out == (received_message_rate_out != 14'h0000))
      else $error("clock enable");
   a_rx_index_map: assert property (
      !direction_select_in |-> freq_select_index_out == receive_select_field_in)
      else $error("rx index");
   a_tx_index_map: assert property (
      direction_select_in |-> freq_select_index_out ==
      {transmit_select_bit_in, message_data_pin_in ~^ data_polarity_direct_in})
      else $error("tx index");
   a_ctrl_reset_word: assert property ($past(rst_in) |-> ctl == 32'h00000057)
      else $error("control reset");
   a_ctrl_hold: assert property (
      !$past(ser_load_n_in, 2) && !$past(rst_in) |-> $stable(ctl))
      else $error("control moved");
   a_code_hold: assert property (
      !$past(ser_load_n_in, 2) && !$past(rst_in) && $stable(freq_select_index_out)
      |-> $stable(freq_code_out))
      else $error("code moved");
   a_oe_quiet: assert property (ser_load_n_in |-> !ser_data_oe_out)
      else $error("drive outside frame");
   a_code_reset: assert property ($past(rst_in) |-> freq_code_out == 32'h00000000)
      else $error("code reset");
endmodule
bind frsc_top frsc_monitor mon (.clock_in(clock_in), .rst_in(rst_in),
   .ser_load_n_in(ser_load_n_in), .ser_data_oe_out(ser_data_oe_out),
   .direction_select_in(direction_select_in), .receive_select_field_in(receive_select_field_in),
   .transmit_select_bit_in(transmit_select_bit_in), .message_data_pin_in(message_data_pin_in),
   .data_polarity_direct_in(data_polarity_direct_in), .freq_code_out(freq_code_out),
   .received_message_rate_out(received_message_rate_out), .sync_step_size_out(sync_step_size_out),
   .recovered_data_clock_enable_out(recovered_data_clock_enable_out),
   .lock_detect_clock_double_out(lock_detect_clock_double_out),
   .unlock_trigger_count_out(unlock_trigger_count_out),
   .lock_trigger_count_out(lock_trigger_count_out), .freq_select_index_out(freq_select_index_out));

//--- testbench/frsc_host.sv
// Purpose: Host end of the three-wire link
// Assumes: Serial clock halves of at least two clock_in cycles
// Notes: Data line shows the inverse of the last bit between frames
module frsc_host (
   input wire logic clock_in,
   input wire logic sdo_in,
   input wire logic oe_in,
   output logic sck_out,
   output logic load_n_out,
   output logic sdi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_out = 1'b0;
      load_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   task automatic xfer(input logic rw, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok, input int nbits);
      logic [36:0] f;
      f = {rw, a, d};
      ok = 1'b1;
      @(posedge clock_in);
      load_n_out <= 1'b0;
      for (int i = 36; i > 36 - nbits; i--) begin
         @(posedge clock_in);
         sdi_out <= f[i];
         sck_out <= 1'b0;
         repeat (2) @(negedge clock_in);
         // Device must drive exactly during read data bits
         if (i < 32) begin
            q[i] = sdo_in;
            ok = ok & (oe_in === rw);
         end
         @(posedge clock_in);
         sck_out <= 1'b1;
         repeat (2) @(posedge clock_in);
      end
      @(posedge clock_in);
      sck_out <= 1'b0;
      load_n_out <= 1'b1;
      sdi_out <= ~f[37 - nbits];
      repeat (3) @(posedge clock_in);
   endtask
endmodule

//--- testbench/freq_register_select_ctrl_tb.sv
// Purpose: Self-checking bench for frsc_top
// Assumes: Host model drives the serial link
// Notes: Selector outputs sampled at falling edges
module freq_register_select_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, sck, ldn, sdi, sdo, oe, dir, txb, pol, pin, ce, lock_detect_clock_double, ok;
   logic [1:0] rxf, idx;
   logic [13:0] rate;
   logic [7:0] step;
   logic [3:0] unl;
   logic [4:0] lck;
   logic [31:0] st, code, q, c1;
   logic [31:0] f [4];
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   frsc_top dut (.clock_in(clk), .rst_in(rst), .ser_clk_in(sck), .ser_load_n_in(ldn),
      .ser_data_in(sdi), .ser_data_out(sdo), .ser_data_oe_out(oe), .direction_select_in(dir),
      .receive_select_field_in(rxf), .transmit_select_bit_in(txb), .status_word_in(st),
      .data_polarity_direct_in(pol), .message_data_pin_in(pin), .freq_code_out(code),
      .received_message_rate_out(rate), .recovered_data_clock_enable_out(ce),
      .sync_step_size_out(step), .lock_detect_clock_double_out(lock_detect_clock_double),
      .unlock_trigger_count_out(unl), .lock_trigger_count_out(lck), .freq_select_index_out(idx));
   frsc_host host (.clock_in(clk), .sdo_in(sdo), .oe_in(oe), .sck_out(sck), .load_n_out(ldn),
      .sdi_out(sdi));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic xs(input logic rw, input logic [3:0] a, input logic [31:0] d);
      host.xfer(rw, a, d, q, ok, 37);
      chk("drive window", 32'h1, {31'h0, ok});
   endtask
   task automatic sel(input logic [5:0] k);
      @(posedge clk);
      {dir, rxf, txb, pol, pin} <= k;
      @(negedge clk);
   endtask
   task automatic t_reset;
      sel(6'h12);
      chk("control", 32'h00000057, {rate, step, lock_detect_clock_double, unl, lck});
      chk("clock enable", 32'h0, {31'h0, ce});
      chk("rx index", 32'h2, {30'h0, idx});
      sel(6'h2B);
      chk("tx index", 32'h1, {30'h0, idx});
   endtask
   task automatic t_ctrl;
      c1 = {14'h0064, 8'hA5, 1'b1, 4'h9, 5'h0C};
      xs(1'b0, 4'h0, c1);
      chk("control", c1, {rate, step, lock_detect_clock_double, unl, lck});
      chk("clock enable", 32'h1, {31'h0, ce});
      xs(1'b1, 4'h0, 32'h0);
      chk("control read", c1, q);
   endtask
   task automatic t_cut;
      host.xfer(1'b0, 4'h0, 32'h0, q, ok, 20);
      chk("cut drive window", 32'h1, {31'h0, ok});
      chk("cut frame", c1, {rate, step, lock_detect_clock_double, unl, lck});
   endtask
   task automatic t_freq;
      logic [1:0] e;
      for (int i = 0; i < 4; i++) begin
         f[i] = 32'hA5C30F00 ^ (32'h11111111 * i);
         xs(1'b0, 4'(i + 1), f[i]);
      end
      for (int i = 0; i < 4; i++) begin
         xs(1'b1, 4'(i + 1), 32'h0);
         chk("code read", f[i], q);
      end
      for (int k = 0; k < 64; k++) begin
         sel(6'(k));
         e = k[5] ? {k[2], k[0] ~^ k[1]} : k[4:3];
         chk("index", {30'h0, e}, {30'h0, idx});
         chk("code", f[e], code);
      end
   endtask
   task automatic t_status;
      xs(1'b0, 4'h5, 32'hFFFFFFFF);
      chk("control kept", c1, {rate, step, lock_detect_clock_double, unl, lck});
      xs(1'b1, 4'h5, 32'h0);
      chk("status read", st, q);
      xs(1'b1, 4'hF, 32'h0);
      chk("unmapped read", 32'h0, q);
      xs(1'b1, 4'h1, 32'h0);
      chk("code kept", f[0], q);
   endtask
   initial begin
      rst = 1'b1;
      {dir, rxf, txb, pol, pin} = 6'h12;
      st = 32'h3C5A96E1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_cut();
      t_freq();
      t_status();
      wrap_up();
   end
endmodule
